// ==== fis_regs.svh ====
/*
 Constants of the two-wire slave front end: field positions, counts and codes.
 Assumes inclusion by bare name from the design files; definitions only.
*/
`ifndef FIS_REGS_SVH
`define FIS_REGS_SVH

// bits per unit on the wire, before the acknowledge slot
`define FIS_LAST_BIT   4'h8
`define FIS_CNT_ZERO   4'h0
`define FIS_CNT_ONE    4'h1
// address word layout: type code, strap code, direction
`define FIS_TYPE_MSB   7
`define FIS_TYPE_LSB   4
`define FIS_STRAP_MSB  3
`define FIS_STRAP_LSB  1
`define FIS_RW_BIT     0
// arbitrary neutral device type code
`define FIS_TYPE_CODE  4'h6
`define FIS_BYTE_ZERO  8'h00

`endif

// ==== fis_pkg.sv ====
/*
 Types of the two-wire slave front end.
 Assumes nothing of its surroundings.
*/
package fis_pkg;
   typedef enum logic [2:0] {
      ST_IDLE    = 3'h0,
      ST_ADDR    = 3'h1,
      ST_ADDR_AK = 3'h2,
      ST_WR_BYTE = 3'h3,
      ST_WR_AK   = 3'h4,
      ST_RD_BYTE = 3'h5,
      ST_RD_AK   = 3'h6,
      ST_IGNORE  = 3'h7
   } fis_state_t;
endpackage : fis_pkg

// ==== fis_evt_sync.sv ====
/*
 Toggle-to-pulse event crossing into the destination clock domain.
 Assumes the source toggles at most once per three destination cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module fis_evt_sync (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic tgl_in,
   output var  logic pulse_q
);
   logic meta_q;
   logic sync_q;
   logic prev_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q  <= 1'b0;
         sync_q  <= 1'b0;
         prev_q  <= 1'b0;
         pulse_q <= 1'b0;
      end else begin
         meta_q  <= tgl_in;
         sync_q  <= meta_q;
         prev_q  <= sync_q;
         pulse_q <= sync_q ^ prev_q;
      end
   end
endmodule : fis_evt_sync
`default_nettype wire

// ==== fis_slave.sv ====
/*
 Two-wire serial slave front end of a byte-wide memory: start/stop detection,
 address matching against strap pins, acknowledge handshake, open-drain data
 and write-protect gating. Assumes link_clk oversamples scl at least eight
 times per scl period, and that the user side keeps rd_data valid whenever
 rd_req is not pulsing.
*/
// Notes on behaviour
// - answer only when received 3-bit address code equals the strap pins
// - an open strap pin reads as low
// - data line is only pulled low or released, never driven high
// - sample data on scl rise, change output after scl fall
// - write-protect high refuses every write; low allows all writes
// - reads proceed whatever the write-protect level
// - an open write-protect input reads as low, writes enabled
// - data changes only while clock low, except start and stop
// - data falling while clock high is a start
// - data rising while clock high is a stop
// - stop during a read ends it and returns to standby
// - stop during a write ends it; next access may follow at once
// - eight-bit units, receiver pulls data low in ninth clock
// - transmitter releases the data line in the ninth clock
// - stop before the acknowledge abandons the operation to standby
// - after a not-acknowledge the bus is released and left alone
// - upper four address bits must match the device type code
// - last address bit: zero writes, one reads
`timescale 1ns/1ps
`default_nettype none
`include "fis_regs.svh"
module fis_slave (
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   input  wire logic       link_clk,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output wire logic       sda_o,
   output wire logic       sda_oe,
   input  wire logic [2:0] chip_select_strap_pins,
   input  wire logic       wp_i,
   input  wire logic [7:0] rd_data,
   output wire logic       rd_req,
   output wire logic       wr_valid,
   output wire logic [7:0] wr_data,
   output wire logic       wr_refused,
   output wire logic       xfer_stop
);
   // link domain
   logic                 lrst_m_q;
   logic                 link_rst_n;
   logic                 scl_m_q;
   logic                 scl_s_q;
   logic                 scl_p_q;
   logic                 sda_m_q;
   logic                 sda_s_q;
   logic                 sda_p_q;
   logic [2:0]           strap_m_q;
   logic [2:0]           strap_s_q;
   fis_pkg::fis_state_t  state_q;
   logic [3:0]           bit_cnt_q;
   logic [7:0]           shift_q;
   logic                 rw_q;
   logic                 ack_ok_q;
   logic                 sda_oe_q;
   logic                 sda_out_q;
   logic [7:0]           wr_byte_q;
   logic                 wr_tgl_q;
   logic                 rd_tgl_q;
   logic                 stop_tgl_q;
   logic                 rd_ready_q;
   logic                 rd_ack_pulse;
   logic                 scl_rise;
   logic                 scl_fall;
   logic                 start_c;
   logic                 stop_c;
   logic                 byte_end;
   logic                 rd_ask;
   // ref domain
   logic                 wp_m_q;
   logic                 wp_s_q;
   logic [7:0]           rd_hold_q;
   logic                 rd_ack_tgl_q;
   logic                 rd_req_q;
   logic                 wr_valid_q;
   logic [7:0]           wr_data_q;
   logic                 wr_refused_q;
   logic                 stop_q;
   logic                 wr_ev;
   logic                 rd_ev;
   logic                 stop_ev;

   function automatic logic addr_match(input logic [7:0] word,
                                       input logic [2:0] strap);
      addr_match = (word[`FIS_TYPE_MSB:`FIS_TYPE_LSB] == `FIS_TYPE_CODE) &&
                   (word[`FIS_STRAP_MSB:`FIS_STRAP_LSB] == strap);
   endfunction : addr_match

   // reset enters the link domain asynchronously, leaves it synchronously
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         lrst_m_q   <= 1'b0;
         link_rst_n <= 1'b0;
      end else begin
         lrst_m_q   <= 1'b1;
         link_rst_n <= lrst_m_q;
      end
   end

   // pins pass two flops; the third stage only serves edge detection
   always_ff @(posedge link_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         scl_m_q   <= 1'b1;
         scl_s_q   <= 1'b1;
         scl_p_q   <= 1'b1;
         sda_m_q   <= 1'b1;
         sda_s_q   <= 1'b1;
         sda_p_q   <= 1'b1;
         strap_m_q <= 3'h0;
         strap_s_q <= 3'h0;
      end else begin
         scl_m_q   <= scl_i;
         scl_s_q   <= scl_m_q;
         scl_p_q   <= scl_s_q;
         sda_m_q   <= sda_i;
         sda_s_q   <= sda_m_q;
         sda_p_q   <= sda_s_q;
         // open straps are pulled down outside, so they arrive as zero
         strap_m_q <= chip_select_strap_pins;
         strap_s_q <= strap_m_q;
      end
   end

   assign scl_rise = scl_s_q & ~scl_p_q;
   assign scl_fall = ~scl_s_q & scl_p_q;
   assign start_c  = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
   assign stop_c   = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
   assign byte_end = scl_fall && (bit_cnt_q == `FIS_LAST_BIT);
   assign rd_ask   = !start_c && !stop_c && scl_fall &&
                     (((state_q == fis_pkg::ST_ADDR_AK) && rw_q) ||
                      ((state_q == fis_pkg::ST_RD_AK) && ack_ok_q));

   always_ff @(posedge link_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         state_q   <= fis_pkg::ST_IDLE;
         bit_cnt_q <= `FIS_CNT_ZERO;
         shift_q   <= `FIS_BYTE_ZERO;
         rw_q      <= 1'b0;
         ack_ok_q  <= 1'b0;
      end else if (start_c) begin
         // a repeated start also lands here, from any state
         state_q   <= fis_pkg::ST_ADDR;
         bit_cnt_q <= `FIS_CNT_ZERO;
      end else if (stop_c) begin
         state_q   <= fis_pkg::ST_IDLE;
      end else begin
         case (state_q)
            fis_pkg::ST_ADDR: begin
               if (scl_rise) begin
                  shift_q   <= {shift_q[6:0], sda_s_q};
                  bit_cnt_q <= bit_cnt_q + `FIS_CNT_ONE;
               end else if (byte_end) begin
                  if (addr_match(shift_q, strap_s_q)) begin
                     state_q <= fis_pkg::ST_ADDR_AK;
                     rw_q    <= shift_q[`FIS_RW_BIT];
                  end else begin
                     state_q <= fis_pkg::ST_IGNORE;
                  end
               end
            end
            fis_pkg::ST_ADDR_AK: begin
               if (scl_fall) begin
                  bit_cnt_q <= `FIS_CNT_ZERO;
                  if (rw_q) begin
                     state_q <= fis_pkg::ST_RD_BYTE;
                  end else begin
                     state_q <= fis_pkg::ST_WR_BYTE;
                  end
               end
            end
            fis_pkg::ST_WR_BYTE: begin
               if (scl_rise) begin
                  shift_q   <= {shift_q[6:0], sda_s_q};
                  bit_cnt_q <= bit_cnt_q + `FIS_CNT_ONE;
               end else if (byte_end) begin
                  state_q <= fis_pkg::ST_WR_AK;
               end
            end
            fis_pkg::ST_WR_AK: begin
               if (scl_fall) begin
                  state_q   <= fis_pkg::ST_WR_BYTE;
                  bit_cnt_q <= `FIS_CNT_ZERO;
               end
            end
            fis_pkg::ST_RD_BYTE: begin
               // the byte is taken only once its capture has crossed back
               if (rd_ack_pulse && (bit_cnt_q == `FIS_CNT_ZERO)) begin
                  shift_q <= rd_hold_q;
               end else if (scl_rise) begin
                  bit_cnt_q <= bit_cnt_q + `FIS_CNT_ONE;
               end else if (byte_end) begin
                  state_q <= fis_pkg::ST_RD_AK;
               end else if (scl_fall) begin
                  shift_q <= {shift_q[6:0], 1'b0};
               end
            end
            fis_pkg::ST_RD_AK: begin
               if (scl_rise) begin
                  ack_ok_q <= ~sda_s_q;
               end else if (scl_fall) begin
                  bit_cnt_q <= `FIS_CNT_ZERO;
                  if (ack_ok_q) begin
                     state_q <= fis_pkg::ST_RD_BYTE;
                  end else begin
                     state_q <= fis_pkg::ST_IGNORE;
                  end
               end
            end
            fis_pkg::ST_IDLE,
            fis_pkg::ST_IGNORE: begin
               state_q <= state_q;
            end
            default: begin
               state_q <= fis_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // open drain: the output level is always low, only the enable moves
   always_ff @(posedge link_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         sda_oe_q  <= 1'b0;
         sda_out_q <= 1'b0;
      end else begin
         sda_out_q <= 1'b0;
         sda_oe_q  <= (state_q == fis_pkg::ST_ADDR_AK) ||
                      (state_q == fis_pkg::ST_WR_AK) ||
                      ((state_q == fis_pkg::ST_RD_BYTE) && rd_ready_q && !shift_q[7]);
      end
   end

   // events towards the user side, each as a toggle
   always_ff @(posedge link_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         wr_byte_q  <= `FIS_BYTE_ZERO;
         wr_tgl_q   <= 1'b0;
         rd_tgl_q   <= 1'b0;
         stop_tgl_q <= 1'b0;
      end else begin
         if (!start_c && !stop_c && byte_end && (state_q == fis_pkg::ST_WR_BYTE)) begin
            wr_byte_q <= shift_q;
            wr_tgl_q  <= ~wr_tgl_q;
         end
         // asked for as the slot opens, put on the wire when it returns
         if (rd_ask) begin
            rd_tgl_q <= ~rd_tgl_q;
         end
         if (stop_c) begin
            stop_tgl_q <= ~stop_tgl_q;
         end
      end
   end

   // rd_hold_q is only trusted once its capture has come back
   always_ff @(posedge link_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         rd_ready_q <= 1'b1;
      end else if (rd_ack_pulse) begin
         rd_ready_q <= 1'b1;
      end else if (rd_ask) begin
         rd_ready_q <= 1'b0;
      end
   end

   fis_evt_sync u_rd_ack (
      .clk     (link_clk),
      .rst_n   (link_rst_n),
      .tgl_in  (rd_ack_tgl_q),
      .pulse_q (rd_ack_pulse)
   );

   fis_evt_sync u_wr_ev (
      .clk     (ref_clk),
      .rst_n   (rst_n),
      .tgl_in  (wr_tgl_q),
      .pulse_q (wr_ev)
   );

   fis_evt_sync u_rd_ev (
      .clk     (ref_clk),
      .rst_n   (rst_n),
      .tgl_in  (rd_tgl_q),
      .pulse_q (rd_ev)
   );

   fis_evt_sync u_stop_ev (
      .clk     (ref_clk),
      .rst_n   (rst_n),
      .tgl_in  (stop_tgl_q),
      .pulse_q (stop_ev)
   );

   // write protect; an open pin is pulled down outside and reads low
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_m_q <= 1'b0;
         wp_s_q <= 1'b0;
      end else begin
         wp_m_q <= wp_i;
         wp_s_q <= wp_m_q;
      end
   end

   // wr_byte_q is stable for a whole byte time after its toggle
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_valid_q   <= 1'b0;
         wr_refused_q <= 1'b0;
         wr_data_q    <= `FIS_BYTE_ZERO;
      end else begin
         wr_valid_q   <= wr_ev && !wp_s_q;
         wr_refused_q <= wr_ev && wp_s_q;
         if (wr_ev) begin
            wr_data_q <= wr_byte_q;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_hold_q    <= `FIS_BYTE_ZERO;
         rd_ack_tgl_q <= 1'b0;
         rd_req_q     <= 1'b0;
         stop_q       <= 1'b0;
      end else begin
         rd_req_q <= rd_ev;
         stop_q   <= stop_ev;
         if (rd_ev) begin
            rd_hold_q    <= rd_data;
            rd_ack_tgl_q <= ~rd_ack_tgl_q;
         end
      end
   end

   assign sda_o      = sda_out_q;
   assign sda_oe     = sda_oe_q;
   assign rd_req     = rd_req_q;
   assign wr_valid   = wr_valid_q;
   assign wr_data    = wr_data_q;
   assign wr_refused = wr_refused_q;
   assign xfer_stop  = stop_q;

   sequence s_quiet;
      !start_c && !stop_c;
   endsequence

   sequence s_write_byte_end;
      (state_q == fis_pkg::ST_WR_BYTE) && byte_end ##0 s_quiet;
   endsequence

   property p_oe_only_in_slots;
      @(posedge link_clk) disable iff (!link_rst_n)
      sda_oe_q |-> $past(state_q == fis_pkg::ST_ADDR_AK || state_q == fis_pkg::ST_WR_AK ||
                         state_q == fis_pkg::ST_RD_BYTE);
   endproperty
   a_oe_only_in_slots: assert property (p_oe_only_in_slots) else $error("data pulled low outside a slot");

   property p_oe_moves_after_fall;
      @(posedge link_clk) disable iff (!link_rst_n)
      $rose(sda_oe_q) |-> ($past(scl_fall, 2) || $past(rd_ack_pulse, 2)) && !scl_s_q;
   endproperty
   a_oe_moves_after_fall: assert property (p_oe_moves_after_fall) else $error("data driven not after fall");

   property p_addr_match;
      @(posedge link_clk) disable iff (!link_rst_n)
      (state_q == fis_pkg::ST_ADDR) ##1 (state_q == fis_pkg::ST_ADDR_AK) |->
         ($past(shift_q[3:1]) == strap_s_q) && ($past(shift_q[7:4]) == `FIS_TYPE_CODE);
   endproperty
   a_addr_match: assert property (p_addr_match) else $error("acknowledged a foreign address");

   property p_start_enters_addr;
      @(posedge link_clk) disable iff (!link_rst_n)
      start_c |=> (state_q == fis_pkg::ST_ADDR) && (bit_cnt_q == `FIS_CNT_ZERO);
   endproperty
   a_start_enters_addr: assert property (p_start_enters_addr) else $error("start not taken");

   property p_stop_to_standby;
      @(posedge link_clk) disable iff (!link_rst_n)
      stop_c |=> (state_q == fis_pkg::ST_IDLE) ##1 !sda_oe_q;
   endproperty
   a_stop_to_standby: assert property (p_stop_to_standby) else $error("stop did not release");

   property p_write_ack;
      @(posedge link_clk) disable iff (!link_rst_n)
      s_write_byte_end |=> (state_q == fis_pkg::ST_WR_AK) ##1 sda_oe_q;
   endproperty
   a_write_ack: assert property (p_write_ack) else $error("write byte not acknowledged");

   property p_read_release;
      @(posedge link_clk) disable iff (!link_rst_n)
      (state_q == fis_pkg::ST_RD_AK) [*2] |-> !sda_oe_q;
   endproperty
   a_read_release: assert property (p_read_release) else $error("line held in master ack slot");

   property p_ignore_until_start;
      @(posedge link_clk) disable iff (!link_rst_n)
      (state_q == fis_pkg::ST_IGNORE) && !start_c && !stop_c |=> (state_q == fis_pkg::ST_IGNORE) ##1 !sda_oe_q;
   endproperty
   a_ignore_until_start: assert property (p_ignore_until_start) else $error("ignored bus was touched");

   property p_direction;
      @(posedge link_clk) disable iff (!link_rst_n)
      (state_q == fis_pkg::ST_ADDR_AK) && scl_fall ##0 s_quiet |=>
         (state_q == (rw_q ? fis_pkg::ST_RD_BYTE : fis_pkg::ST_WR_BYTE));
   endproperty
   a_direction: assert property (p_direction) else $error("direction bit not obeyed");

   property p_write_protect;
      @(posedge ref_clk) disable iff (!rst_n)
      wr_ev |=> (wr_valid_q == !$past(wp_s_q)) && (wr_refused_q == $past(wp_s_q));
   endproperty
   a_write_protect: assert property (p_write_protect) else $error("write protect not obeyed");
endmodule : fis_slave
`default_nettype wire

// ==== fis_master_model.sv ====
/*
 Behavioural two-wire bus master: makes the serial clock and pulls data low.
 Assumes a pull-up resolves the data wire outside; the bench calls its tasks.
*/
`timescale 1ns/1ps
`default_nettype none
module fis_master_model #(
   parameter int Q = 100
) (
   input  wire logic sda,
   output var  logic scl,
   output var  logic sda_drv
);
   // clock stands high between frames, only this side drives it
   initial begin
      scl     = 1'b1;
      sda_drv = 1'b0;
   end

   task automatic put_bit(input logic b, output logic s);
      sda_drv = ~b;
      #Q scl = 1'b1;
      #Q s = sda;
      #Q scl = 1'b0;
      #Q;
   endtask : put_bit

   task automatic start;
      sda_drv = 1'b0;
      #Q scl = 1'b1;
      #Q sda_drv = 1'b1;
      #Q scl = 1'b0;
      #Q;
   endtask : start

   task automatic stop;
      sda_drv = 1'b1;
      #Q scl = 1'b1;
      #Q sda_drv = 1'b0;
      #Q;
   endtask : stop

   // short nbits leaves the unit unfinished, for aborts
   task automatic wr_byte(input logic [7:0] b, input int nbits, output logic ack);
      logic s;
      ack = 1'b0;
      for (int i = 7; i > 7 - nbits; i--) begin
         put_bit(b[i], s);
      end
      if (nbits == 8) begin
         put_bit(1'b1, s);
         ack = ~s;
      end
   endtask : wr_byte

   task automatic rd_byte(output logic [7:0] b, input logic ack);
      logic s;
      for (int i = 0; i < 8; i++) begin
         put_bit(1'b1, s);
         b = {b[6:0], s};
      end
      put_bit(~ack, s);
   endtask : rd_byte
endmodule : fis_master_model
`default_nettype wire

// ==== testbench.sv ====
/*
 Self-checking bench of the two-wire slave front end, with a bus master model.
 Assumes the design files and the master model are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
   typedef struct packed {logic [2:0] strap; logic [7:0] addr; logic ack;} fis_row_t;
   logic       ref_clk  = 1'b0;
   logic       link_clk = 1'b0;
   logic       rst_n    = 1'b0;
   logic       scl, sda_drv, sda_w, sda_o, sda_oe;
   // matches the released line, so no false change is seen before reset ends
   logic       oe_prev  = 1'b0;
   logic [2:0] straps   = 3'h0;
   logic       wp       = 1'b0;
   logic [7:0] rd_data  = 8'h00;
   logic       rd_req, wr_valid, wr_refused, xfer_stop, ack;
   logic [7:0] wr_data, rb;
   logic [7:0] wr_q[$];
   int         n_mismatch = 0;
   int         cmp_count  = 0;
   int         n_ref = 0, n_stop = 0, n_rd = 0;
   fis_row_t   rows[6] = '{
      '{3'h5, 8'h6A, 1'b1}, '{3'h5, 8'h68, 1'b0}, '{3'h0, 8'h60, 1'b1},
      '{3'h7, 8'h6E, 1'b1}, '{3'h7, 8'h2E, 1'b0}, '{3'h7, 8'h7E, 1'b0}};

   always #5 ref_clk = ~ref_clk;
   // link clock offset so its edges drift against ref_clk
   initial begin
      #2.7;
      forever #6 link_clk = ~link_clk;
   end

   // pull-up on the data wire
   assign sda_w = (sda_drv | (sda_oe & ~sda_o)) ? 1'b0 : 1'b1;

   fis_master_model #(.Q(100)) i_fis_master_model (.sda(sda_w), .scl(scl), .sda_drv(sda_drv));

   fis_slave i_fis_slave (
      .ref_clk(ref_clk), .rst_n(rst_n), .link_clk(link_clk), .scl_i(scl), .sda_i(sda_w),
      .sda_o(sda_o), .sda_oe(sda_oe), .chip_select_strap_pins(straps), .wp_i(wp),
      .rd_data(rd_data), .rd_req(rd_req), .wr_valid(wr_valid), .wr_data(wr_data),
      .wr_refused(wr_refused), .xfer_stop(xfer_stop));

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : tally_and_finish

   task automatic send(input logic [7:0] b, input logic exp_ack, input string what);
      i_fis_master_model.wr_byte(b, 8, ack);
      check(what, {7'h00, ack}, {7'h00, exp_ack});
   endtask : send

   // user side: one pulse per event; next read byte offered after each request
   always @(posedge ref_clk) begin
      if (wr_valid === 1'b1) wr_q.push_back(wr_data);
      if (wr_refused === 1'b1) n_ref++;
      if (xfer_stop === 1'b1) n_stop++;
      if (rd_req === 1'b1) begin
         n_rd++;
         rd_data <= rd_data + 8'h11;
      end
   end

   // wire watch, away from the link register's own edge
   always @(negedge link_clk) begin
      if (sda_oe === 1'b1) check("sda_o level", {7'h00, sda_o}, 8'h00);
      if (sda_oe !== oe_prev) check("scl at sda change", {7'h00, scl}, 8'h00);
      oe_prev <= sda_oe;
   end

   initial begin
      #300us;
      n_mismatch++;
      tally_and_finish();
   end

   initial begin
      repeat (16) @(posedge ref_clk);
      check("oe in reset", {7'h00, sda_oe}, 8'h00);
      check("pulses in reset", {5'h00, rd_req, wr_valid, xfer_stop}, 8'h00);
      $display("reset test done");
      rst_n <= 1'b1;
      repeat (20) @(posedge ref_clk);
      foreach (rows[i]) begin
         straps <= rows[i].strap;
         repeat (10) @(posedge ref_clk);
         i_fis_master_model.start();
         send(rows[i].addr, rows[i].ack, "addr ack");
         if (!rows[i].ack) send(8'h00, 1'b0, "ignored ack");
         i_fis_master_model.stop();
         $display("address row %0d done", i);
      end
      straps <= 3'h5;
      wr_q.delete();
      n_stop = 0;
      repeat (10) @(posedge ref_clk);
      i_fis_master_model.start();
      send(8'h6A, 1'b1, "write addr ack");
      send(8'hA5, 1'b1, "data ack");
      send(8'h3C, 1'b1, "data ack");
      i_fis_master_model.stop();
      i_fis_master_model.start();
      send(8'h6A, 1'b1, "restart ack");
      send(8'hC3, 1'b1, "data ack");
      i_fis_master_model.wr_byte(8'h50, 4, ack);
      i_fis_master_model.stop();
      repeat (20) @(posedge ref_clk);
      check("writes", 8'(wr_q.size()), 8'h03);
      if (wr_q.size() == 3) begin
         check("wr_data 0", wr_q[0], 8'hA5);
         check("wr_data 1", wr_q[1], 8'h3C);
         check("wr_data 2", wr_q[2], 8'hC3);
      end
      check("stops", 8'(n_stop), 8'h02);
      $display("write test done");
      wp <= 1'b1;
      repeat (10) @(posedge ref_clk);
      i_fis_master_model.start();
      send(8'h6A, 1'b1, "wp addr ack");
      send(8'h99, 1'b1, "wp data ack");
      i_fis_master_model.stop();
      repeat (20) @(posedge ref_clk);
      check("refused", 8'(n_ref), 8'h01);
      check("writes under wp", 8'(wr_q.size()), 8'h03);
      $display("protect test done");
      rd_data <= 8'h5A;
      n_rd = 0;
      repeat (2) @(posedge ref_clk);
      i_fis_master_model.start();
      send(8'h6B, 1'b1, "read addr ack");
      i_fis_master_model.rd_byte(rb, 1'b1);
      check("read 0", rb, 8'h5A);
      i_fis_master_model.rd_byte(rb, 1'b0);
      check("read 1", rb, 8'h6B);
      send(8'hFF, 1'b0, "after nack");
      i_fis_master_model.stop();
      repeat (20) @(posedge ref_clk);
      check("read requests", 8'(n_rd), 8'h02);
      i_fis_master_model.start();
      send(8'h6A, 1'b1, "after read stop");
      i_fis_master_model.stop();
      $display("read test done");
      tally_and_finish();
   end
endmodule : testbench
`default_nettype wire
